// file: logic/mfr_receiver.sv
// Four-channel multifrequency tone receiver: input, filters, decode, output
// Function
// - Up to four channels, each detected independently.
// - Incoming samples are mu-law companded.
// - Samples gated by enables; input holds one until the filter takes it, dropping any offered meanwhile.
// - Expand each sample to linear, then square it for energy.
// - Six tone filters feed the serial accumulator.
// - Sequencer aligns to first sample and realigns on every sample.
// - Sequencer paces filters and the decoder.
// - Accumulator gathers two bytes per filter into one sum.
// - Sums written straight into decoder memory by DMA.
// - Digits 1-6 from pairs among 700/900/1100/1300 Hz.
// - Digits 7,8,9,0 from a tone plus 1500 Hz.
// - Start, end of pulsing, operator position use 1700 Hz pairs.
// - Decoded tone becomes a binary code returned on transmit bus.
// - The code is eight bits wide.
// - Code driven on transmit bus only when this channel is scanned.
`timescale 1ns/10ps
module mfr_receiver #(
    parameter int NCH = mfr_pkg::CHANNELS,
    parameter int BLOCK = mfr_pkg::BLOCK_LEN
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Receive PCM bus
    input wire logic [mfr_pkg::SAMPLE_W-1:0] receivePcmBus,
    input wire logic rxEnable,
    input wire logic [mfr_pkg::CH_W-1:0] rxChannel,
    // Transmit PCM bus
    input wire logic txScan,
    input wire logic [mfr_pkg::CH_W-1:0] txChannel,
    output logic [7:0] transmitPcmBus,
    output logic transmitPcmBusOe,
    // Detection level
    input wire logic [mfr_pkg::SUM_W-1:0] threshold,
    // Decoder memory write port
    output logic dmaWrite,
    output logic [mfr_pkg::ADDR_W-1:0] dmaAddr,
    output logic [mfr_pkg::SUM_W-1:0] dmaData
);
    import mfr_pkg::*;
    // =========================================================
    // Elaboration checks
    // Counters and filter sets exist only up to the package limits
    if (NCH < 1 || NCH > CHANNELS ||
            BLOCK < 2 || BLOCK > BLOCK_LEN) begin : g_bad_params
        $error("mfr_receiver: unsupported parameters");
    end
    // The memory address packs channel and filter index side by side
    if (ADDR_W != CH_W + 3 || FILTERS > 8) begin : g_bad_layout
        $error("mfr_receiver: address layout does not fit");
    end
    // =========================================================
    // Channel range
    function automatic logic chan_ok(
        input logic [CH_W-1:0] ch
    );
        // Compared as int: NCH itself does not fit the channel field
        return int'(ch) < NCH;
    endfunction : chan_ok
    // =========================================================
    // State
    typedef struct packed {
        mfr_state_t state;
        logic [SAMPLE_W-1:0] hold;
        logic [CH_W-1:0] holdCh;
        logic holdFull;
        logic synced;
        logic [CHANNELS-1:0][BLOCK_W-1:0] count;
        logic [CH_W-1:0] workCh;
        logic [ENERGY_W-1:0] energy;
        logic [2:0] idx;
        logic [FILTERS-1:0][SUM_W-1:0] sums;
        logic [CHANNELS-1:0][7:0] code;
        logic [7:0] txData;
        logic txOe;
        logic dmaWr;
        logic [ADDR_W-1:0] dmaA;
        logic [SUM_W-1:0] dmaD;
    } mfr_st_t;
    mfr_st_t st_r, st_nxt;
    // =========================================================
    // Filter bank, one set per channel
    logic [CHANNELS-1:0][FILTERS-1:0][SUM_W-1:0] level;
    logic [CHANNELS-1:0] chStep, chClear;
    logic [LIN_W-1:0] linear;
    // Expansion reads the holder, so a sample stays put until used
    assign linear = mfr_expand(st_r.hold);
    genvar c, f;
    generate
        for (c = 0; c < CHANNELS; c++) begin : g_ch
            for (f = 0; f < FILTERS; f++) begin : g_f
                // Slower leak for higher tones keeps bandwidths alike
                // Steps only on samples of its own channel
                mfr_tone_filter #(.SHIFT(2 + f / 2)) u_filt (
                    .sys_clk(sys_clk),
                    .resetn(resetn),
                    .step(chStep[c]),
                    .clear(chClear[c]),
                    .energy(st_r.energy),
                    .level(level[c][f])
                );
            end
        end
    endgenerate
    // =========================================================
    // Decoder
    function automatic logic [7:0] mfr_decode(
        input logic [FILTERS-1:0] hit
    );
        logic [7:0] d;
        d = CODE_INVALID;
        unique case (hit)
            6'b000000: d = CODE_PAUSE;
            6'b000011: d = CODE_DIGIT | 8'h01;
            6'b000101: d = CODE_DIGIT | 8'h02;
            6'b000110: d = CODE_DIGIT | 8'h03;
            6'b001001: d = CODE_DIGIT | 8'h04;
            6'b001010: d = CODE_DIGIT | 8'h05;
            6'b001100: d = CODE_DIGIT | 8'h06;
            6'b010001: d = CODE_DIGIT | 8'h07;
            6'b010010: d = CODE_DIGIT | 8'h08;
            6'b010100: d = CODE_DIGIT | 8'h09;
            6'b011000: d = CODE_DIGIT;
            6'b100100: d = CODE_START_DIGITS;
            6'b110000: d = CODE_END_PULSING;
            6'b100010: d = CODE_OPERATOR;
            default: d = ($countones(hit) > 2) ? CODE_THREE : CODE_INVALID;
        endcase
        return d;
    endfunction : mfr_decode
    logic [FILTERS-1:0] hit;
    // A sum must lie strictly above the level to count as a hit
    always_comb begin
        for (int i = 0; i < FILTERS; i++) begin
            hit[i] = st_r.sums[i] > threshold;
        end
    end
    // =========================================================
    // Sequencer
    always_comb begin
        st_nxt = st_r;
        st_nxt.dmaWr = 1'b0;
        chStep = '0;
        chClear = '0;
        // Input holder, refilled only when empty; a sample offered
        // while it is full is lost, so the far side must pace delivery
        if (rxEnable && !st_r.holdFull && chan_ok(rxChannel)) begin
            st_nxt.hold = receivePcmBus;
            st_nxt.holdCh = rxChannel;
            st_nxt.holdFull = 1'b1;
        end
        unique case (st_r.state)
            MFR_IDLE: begin
                if (st_r.holdFull) begin
                    // Align on this sample
                    st_nxt.synced = 1'b1;
                    st_nxt.workCh = st_r.holdCh;
                    st_nxt.energy = ENERGY_W'(linear * linear);
                    st_nxt.holdFull = 1'b0;
                    st_nxt.state = MFR_FILT;
                end
            end
            MFR_FILT: begin
                chStep[st_r.workCh] = 1'b1;
                if (st_r.count[st_r.workCh] == BLOCK_W'(BLOCK - 1)) begin
                    st_nxt.count[st_r.workCh] = '0;
                    // Level before this step: a sum spans BLOCK-1 updates
                    for (int i = 0; i < FILTERS; i++) begin
                        st_nxt.sums[i] = level[st_r.workCh][i];
                    end
                    st_nxt.idx = '0;
                    st_nxt.state = MFR_DUMP;
                end else begin
                    st_nxt.count[st_r.workCh] = st_r.count[st_r.workCh] + 1'b1;
                    st_nxt.state = MFR_IDLE;
                end
            end
            MFR_DUMP: begin
                // One 16-bit sum per filter into decoder memory
                // Six cycles; the holder keeps one sample meanwhile
                st_nxt.dmaWr = 1'b1;
                st_nxt.dmaA = {st_r.workCh, st_r.idx};
                st_nxt.dmaD = st_r.sums[st_r.idx];
                st_nxt.idx = st_r.idx + 1'b1;
                if (st_r.idx == 3'(FILTERS - 1)) begin
                    st_nxt.state = MFR_DECODE;
                end
            end
            MFR_DECODE: begin
                st_nxt.code[st_r.workCh] = mfr_decode(hit);
                // Next block of this channel starts from zero
                chClear[st_r.workCh] = 1'b1;
                st_nxt.state = MFR_IDLE;
            end
        endcase
        // Trunk output logic drives only on this card's scan; registered,
        // so the bus answers on the edge after the scan strobe
        st_nxt.txOe = txScan && chan_ok(txChannel);
        st_nxt.txData = st_nxt.txOe ? st_r.code[txChannel] : 8'h00;
    end
    // =========================================================
    // Registers
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
            st_r.state <= MFR_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end
    // =========================================================
    // Outputs
    assign transmitPcmBus = st_r.txData;
    assign transmitPcmBusOe = st_r.txOe;
    assign dmaWrite = st_r.dmaWr;
    assign dmaAddr = st_r.dmaA;
    assign dmaData = st_r.dmaD;
endmodule : mfr_receiver

// file: logic/mfr_pkg.sv
// Package: constants, types and helpers of the four-channel tone receiver
package mfr_pkg;
    // =========================================================
    // Sizes
    localparam int CHANNELS = 4;
    localparam int FILTERS = 6;
    localparam int CH_W = 2;
    localparam int SAMPLE_W = 8;
    localparam int LIN_W = 14;
    localparam int ENERGY_W = 28;
    localparam int SUM_W = 16;
    localparam int BLOCK_LEN = 64;
    localparam int BLOCK_W = 6;
    localparam int ADDR_W = 5;
    localparam logic [SUM_W-1:0] THRESH_RST = 16'h0400;
    // =========================================================
    // Tone indices: 700, 900, 1100, 1300, 1500, 1700 Hz
    localparam int T700 = 0;
    localparam int T900 = 1;
    localparam int T1100 = 2;
    localparam int T1300 = 3;
    localparam int T1500 = 4;
    localparam int T1700 = 5;
    // =========================================================
    // Output code values
    localparam logic [7:0] CODE_PAUSE = 8'h00;
    localparam logic [7:0] CODE_DIGIT = 8'h80;
    localparam logic [7:0] CODE_START_DIGITS = 8'h8a;
    localparam logic [7:0] CODE_END_PULSING = 8'h8b;
    localparam logic [7:0] CODE_OPERATOR = 8'h8c;
    localparam logic [7:0] CODE_INVALID = 8'hbf;
    localparam logic [7:0] CODE_THREE = 8'hbc;

    typedef enum logic [1:0] {
        MFR_IDLE = 2'b00,
        MFR_FILT = 2'b01,
        MFR_DUMP = 2'b11,
        MFR_DECODE = 2'b10
    } mfr_state_t;

    // Mu-law to linear magnitude (sign dropped, energy is squared)
    function automatic logic [LIN_W-1:0] mfr_expand(
        input logic [SAMPLE_W-1:0] code
    );
        logic [7:0] inv;
        logic [LIN_W-1:0] mag;
        inv = ~code;
        // Segment step plus bias of 33, so the largest code fits LIN_W
        mag = LIN_W'({inv[3:0], 1'b1}) + LIN_W'(32);
        mag = mag << inv[6:4];
        return mag - LIN_W'(33);
    endfunction : mfr_expand
endpackage : mfr_pkg

// file: logic/mfr_tone_filter.sv
// Single-pole resonator that tracks the energy near one tone
`timescale 1ns/10ps
module mfr_tone_filter #(
    parameter int SHIFT = 3
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Sample stream
    input wire logic step,
    input wire logic clear,
    input wire logic [mfr_pkg::ENERGY_W-1:0] energy,
    // Result
    output logic [mfr_pkg::SUM_W-1:0] level
);
    import mfr_pkg::*;
    if (SHIFT < 1 || SHIFT > 8) begin : g_bad_shift
        $error("mfr_tone_filter: SHIFT out of range");
    end
    typedef struct packed {
        logic [ENERGY_W-1:0] acc;
    } mfr_tf_t;
    mfr_tf_t st_r, st_nxt;
    logic [ENERGY_W-1:0] leak;
    assign leak = st_r.acc >> SHIFT;
    always_comb begin
        st_nxt = st_r;
        if (clear) begin
            st_nxt.acc = '0;
        end else if (step) begin
            st_nxt.acc = st_r.acc - leak + (energy >> SHIFT);
        end
    end
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign level = st_r.acc[ENERGY_W-1 -: SUM_W];
endmodule : mfr_tone_filter

// file: testbench/mfr_assertions.sv
// Port checker of the four-channel tone receiver
`timescale 1ns/10ps
module mfr_assertions #(
    parameter int NCH = 4,
    parameter int BLOCK = 64
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Receive and transmit buses
    input wire logic [7:0] receivePcmBus,
    input wire logic rxEnable,
    input wire logic [1:0] rxChannel,
    input wire logic txScan,
    input wire logic [1:0] txChannel,
    input wire logic [7:0] transmitPcmBus,
    input wire logic transmitPcmBusOe,
    // Level and memory port
    input wire logic [15:0] threshold,
    input wire logic dmaWrite,
    input wire logic [4:0] dmaAddr,
    input wire logic [15:0] dmaData
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence s_burst; dmaWrite [*6] ##1 !dmaWrite; endsequence
    property p_burst; $rose(dmaWrite) |-> s_burst; endproperty
    a_burst: assert property (p_burst) else $error("bad burst");
    property p_order;
        dmaWrite && $past(dmaWrite) |-> dmaAddr == $past(dmaAddr) + 5'h01;
    endproperty
    a_order: assert property (p_order) else $error("bad order");
    property p_range; dmaWrite |-> dmaAddr[2:0] < 3'h6; endproperty
    a_range: assert property (p_range) else $error("bad filter");
    property p_first; $rose(dmaWrite) |-> dmaAddr[2:0] == 3'h0; endproperty
    a_first: assert property (p_first) else $error("bad start");
    property p_cause;
        $rose(dmaWrite) |->
            $past(rxEnable, 3) || $past(rxEnable, 4) || $past(rxEnable, 5);
    endproperty
    a_cause: assert property (p_cause) else $error("no pacing");
    property p_drive; txScan && txChannel < NCH |=> transmitPcmBusOe;
    endproperty
    a_drive: assert property (p_drive) else $error("no drive");
    property p_quiet;
        !txScan |=> !transmitPcmBusOe && transmitPcmBus == 8'h00;
    endproperty
    a_quiet: assert property (p_quiet) else $error("stray drive");
    property p_fmt;
        transmitPcmBusOe |-> transmitPcmBus[7] || transmitPcmBus == 8'h00;
    endproperty
    a_fmt: assert property (p_fmt) else $error("bad code");
endmodule : mfr_assertions
bind mfr_receiver mfr_assertions #(.NCH(NCH), .BLOCK(BLOCK)) i_chk (
    .sys_clk(sys_clk), .resetn(resetn), .receivePcmBus(receivePcmBus),
    .rxEnable(rxEnable), .rxChannel(rxChannel), .txScan(txScan),
    .txChannel(txChannel), .transmitPcmBus(transmitPcmBus),
    .transmitPcmBusOe(transmitPcmBusOe), .threshold(threshold),
    .dmaWrite(dmaWrite), .dmaAddr(dmaAddr), .dmaData(dmaData)
);

// file: testbench/mfr_trunk_model.sv
// Trunk module model: mu-law samples round the four channels
`timescale 1ns/10ps
module mfr_trunk_model (
    // Clock, reset and control
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic run,
    input wire logic [3:0] loudMask,
    // Receive PCM bus
    output logic [7:0] receivePcmBus,
    output logic rxEnable,
    output logic [1:0] rxChannel
);
    int gap;
    logic [7:0] sent;
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            gap <= 0;
            sent <= 8'h00;
            rxEnable <= 1'b0;
            rxChannel <= 2'h0;
            receivePcmBus <= 8'h5a;
        end else if (gap > 0 || !run) begin
            gap <= gap - 1;
            rxEnable <= 1'b0;
            receivePcmBus <= ~receivePcmBus;
        end else begin
            rxEnable <= 1'b1;
            rxChannel <= sent[1:0];
            receivePcmBus <= loudMask[sent[1:0]] ? 8'h00 : 8'hff;
            sent <= sent + 8'h01;
            gap <= (sent[7:2] == 6'h3f) ? 13 : 3;
        end
    end
endmodule : mfr_trunk_model

// file: testbench/tb_top.sv
// Testbench of the four-channel tone receiver
`timescale 1ns/10ps
module tb_top;
    import mfr_pkg::*;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic run = 1'b0;
    logic [3:0] loudMask = 4'h2;
    logic [7:0] receivePcmBus, transmitPcmBus;
    logic rxEnable, transmitPcmBusOe, dmaWrite;
    logic [1:0] rxChannel;
    logic txScan = 1'b0;
    logic [1:0] txChannel = 2'h0;
    logic [15:0] threshold = THRESH_RST;
    logic [4:0] dmaAddr;
    logic [15:0] dmaData;
    int failures = 0;
    int checked = 0;
    int dmaCount [4] = '{0, 0, 0, 0};
    always #10 sys_clk = ~sys_clk;
    mfr_trunk_model i_trunk (.sys_clk(sys_clk), .resetn(resetn), .run(run),
        .loudMask(loudMask), .receivePcmBus(receivePcmBus),
        .rxEnable(rxEnable), .rxChannel(rxChannel));
    mfr_receiver #(.NCH(4), .BLOCK(64)) i_dut (.sys_clk(sys_clk),
        .resetn(resetn), .receivePcmBus(receivePcmBus), .rxEnable(rxEnable),
        .rxChannel(rxChannel), .txScan(txScan), .txChannel(txChannel),
        .transmitPcmBus(transmitPcmBus), .transmitPcmBusOe(transmitPcmBusOe),
        .threshold(threshold), .dmaWrite(dmaWrite), .dmaAddr(dmaAddr),
        .dmaData(dmaData));
    task automatic compare(input string what, input logic [15:0] exp, got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : compare
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish
    // Silent channels must write zero sums
    always @(posedge sys_clk) begin
        if (dmaWrite === 1'b1) begin
            dmaCount[dmaAddr[4:3]]++;
            if (!loudMask[dmaAddr[4:3]])
                compare("silent sum", 16'h0000, dmaData);
            else
                compare("loud sum", 16'h0001,
                    {15'h0, dmaData > THRESH_RST});
        end
    end
    task automatic wait_blocks(input int n);
        for (int i = 0; i < 6000 && dmaCount[3] < n; i++) @(posedge sys_clk);
        if (dmaCount[3] < n) begin
            failures++;
            $display("MISMATCH dma words expected %0d seen %0d", n,
                dmaCount[3]);
            tally_and_finish();
        end
    endtask : wait_blocks
    task automatic scan(input logic [1:0] ch, input logic [7:0] exp, mask);
        @(posedge sys_clk);
        txScan <= 1'b1;
        txChannel <= ch;
        @(posedge sys_clk);
        txScan <= 1'b0;
        #1;
        compare("oe", 16'h0001, {15'h0, transmitPcmBusOe});
        compare("code", {8'h0, exp}, {8'h0, transmitPcmBus & mask});
    endtask : scan
    // ===========================================================
    // Scenarios
    task automatic test_idle;
        repeat (3) @(posedge sys_clk);
        #1;
        compare("idle oe", 16'h0000, {15'h0, transmitPcmBusOe});
        compare("idle dma", 16'h0000, {15'h0, dmaWrite});
        $display("test_idle done");
    endtask : test_idle
    task automatic test_blocks;
        @(posedge sys_clk);
        run <= 1'b1;
        wait_blocks(12);
        for (int c = 0; c < 4; c++)
            compare("words", 16'd12, 16'(dmaCount[c]));
        scan(2'h0, CODE_PAUSE, 8'hff);
        scan(2'h1, CODE_THREE, 8'hff);
        scan(2'h2, CODE_PAUSE, 8'hff);
        scan(2'h3, CODE_PAUSE, 8'hff);
        $display("test_blocks done");
    endtask : test_blocks
    task automatic test_reset;
        @(posedge sys_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        compare("reset oe", 16'h0000, {15'h0, transmitPcmBusOe});
        compare("reset bus", 16'h0000, {8'h0, transmitPcmBus});
        compare("reset dma", 16'h0000, {15'h0, dmaWrite});
        @(posedge sys_clk);
        resetn <= 1'b1;
        scan(2'h1, CODE_PAUSE, 8'hff);
        $display("test_reset done");
    endtask : test_reset
    task automatic test_threshold;
        @(posedge sys_clk);
        threshold <= 16'hffff;
        wait_blocks(24);
        scan(2'h1, CODE_PAUSE, 8'hff);
        $display("test_threshold done");
    endtask : test_threshold
    initial begin
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        test_idle();
        test_blocks();
        test_reset();
        test_threshold();
        tally_and_finish();
    end
endmodule : tb_top
